// file: oag_adder.sv
/*
  Three-operand 16-bit address adder, wraps modulo 2^16.
  Assumes operands are already zero-extended.
*/
module oag_adder (
  oag_mem_if.alu m  // Operand carrier
);
  wire [17:0] full_sum;

  assign full_sum = {2'b00, m.base} + {2'b00, m.offs} + {2'b00, m.extra};
  assign m.sum    = full_sum[15:0];
endmodule

// file: oag_mem_if.sv
/*
  Adder operands and sum between the generator and its adder.
  Assumes one clock domain.
*/
interface oag_mem_if;
  logic [15:0] base;
  logic [15:0] offs;
  logic [15:0] extra;
  logic [15:0] sum;
  modport ctl (output base, output offs, output extra, input sum);
  modport alu (input base, input offs, input extra, output sum);
endinterface

// file: oag_memory_model.sv
/* Pointer store model: answers a fetch after pdelay extra cycles.
   Assumes ptr_req is high for one cycle per fetch. */
module oag_memory_model (
  input  wire logic        clock,     // Clock
  input  wire logic        ptr_req,   // Fetch request
  input  wire logic [15:0] pdata,     // Pointer to return
  input  wire logic [1:0]  pdelay,    // Extra wait cycles
  output logic             ptr_valid, // Answer strobe
  output logic [15:0]      ptr_data   // Pointer word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ptr_valid = 1'b0;
    ptr_data = 16'h5a5a;
  end
  always @(posedge clock) begin
    if (ptr_req === 1'b1) begin
      repeat (pdelay) @(posedge clock);
      #1 ptr_valid = 1'b1;
      ptr_data = pdata;
      @(posedge clock);
      #1 ptr_valid = 1'b0;
      ptr_data = ~pdata; // Released word must not look valid
    end
  end
endmodule

// file: oag_monitor.sv
/* Port-level assertions for the operand address generator.
   Bound into operand_address_generator; one clock, reset rstn. */
module oag_monitor (
  input wire logic        clock,       // Clock
  input wire logic        rstn,        // Reset, active low
  input wire logic        start,       // Request
  input wire logic [1:0]  addr_class,  // Class
  input wire logic [2:0]  mode,        // Mode
  input wire logic [7:0]  disp,        // Displacement
  input wire logic [15:0] local_base,  // Local base
  input wire logic [15:0] common_base, // Common base
  input wire logic [15:0] ptr_base,    // Pointer base
  input wire logic [15:0] index_reg,   // Index
  input wire logic [15:0] prog_loc,    // Program location
  input wire logic        ptr_req,     // Fetch request
  input wire logic [15:0] ptr_addr,    // Fetch address
  input wire logic        ptr_valid,   // Fetch answer
  input wire logic [15:0] ptr_data,    // Fetched pointer
  input wire logic        done,        // Result strobe
  input wire logic        is_operand,  // Operand flag
  input wire logic        fault,       // Illegal mode
  input wire logic [15:0] result       // Result
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [15:0] d1 = {8'h00, disp};
  wire [15:0] d2 = {7'h00, disp, 1'b0};
  property p_dl; start && addr_class == 2'h0 && mode == 3'h0 |-> ##2 done && !is_operand && result == local_base + d1; endproperty
  a_dl: assert property (p_dl) else $error("direct local wrong");
  property p_dg; start && addr_class == 2'h0 && mode == 3'h3 |-> ##2 done && result == common_base + d1; endproperty
  a_dg: assert property (p_dg) else $error("direct common wrong");
  property p_imm; start && addr_class == 2'h0 && mode == 3'h5 |-> ##2 done && is_operand && result == d1; endproperty
  a_imm: assert property (p_imm) else $error("immediate wrong");
  property p_nimm; start && addr_class == 2'h1 && mode == 3'h5 |-> ##1 fault ##1 !done; endproperty
  a_nimm: assert property (p_nimm) else $error("immediate not refused");
  property p_px; start && addr_class == 2'h2 && mode == 3'h6 |-> ##2 done && is_operand && result == d1 + index_reg; endproperty
  a_px: assert property (p_px) else $error("indexed parameter wrong");
  property p_fwd; start && addr_class == 2'h3 && mode == 3'h7 |-> ##2 done && result == prog_loc + d2; endproperty
  a_fwd: assert property (p_fwd) else $error("forward target wrong");
  property p_bwd; start && addr_class == 2'h3 && mode == 3'h6 |-> ##2 done && result == prog_loc - d2; endproperty
  a_bwd: assert property (p_bwd) else $error("backward target wrong");
  property p_ilp; start && addr_class == 2'h0 && mode == 3'h1 |-> ##1 ptr_req && ptr_addr == local_base + d1; endproperty
  a_ilp: assert property (p_ilp) else $error("pointer address wrong");
  property p_igx; ptr_valid && addr_class == 2'h0 && mode == 3'h4 |-> ##2 done && result == common_base + $past(ptr_data, 2) + index_reg; endproperty
  a_igx: assert property (p_igx) else $error("common indexed wrong");
  property p_igb; ptr_valid && addr_class == 2'h3 && mode == 3'h4 |-> ##2 done && result == ptr_base + $past(ptr_data, 2); endproperty
  a_igb: assert property (p_igb) else $error("common branch wrong");
endmodule
bind operand_address_generator oag_monitor u_mon (.clock, .rstn, .start, .addr_class, .mode, .disp,
  .local_base, .common_base, .ptr_base, .index_reg, .prog_loc, .ptr_req, .ptr_addr, .ptr_valid,
  .ptr_data, .done, .is_operand, .fault, .result);

// file: oag_pkg.sv
/*
  Shared constants and types for the operand address generator.
  Assumes a 16-bit byte-addressed memory and an 8-bit displacement field.
*/
package oag_pkg;

  localparam int ADDR_W = 16;
  localparam int DISP_W = 8;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] ZERO_EXT = 16'h0000;

  // ****************************************************************
  // Addressing classes and modes
  // ****************************************************************
  typedef enum logic [1:0] {
    class_0,
    class_0p,
    class_1,
    class_2
  } addr_class_t;

  typedef enum logic [2:0] {
    direct_local,
    indirect_local,
    indirect_local_indexed,
    direct_common,
    indirect_common_indexed,
    immediate,
    immediate_indexed,
    relative_forward
  } mode_t;

  // Class 2 reuses codes: relative_backward and indirect_common_branch
  localparam logic [2:0] MODE_RELATIVE_BACKWARD      = 3'h6;
  localparam logic [2:0] MODE_INDIRECT_COMMON_BRANCH = 3'h4;

  typedef enum logic [2:0] {
    st_idle,
    st_ptr_req,
    st_ptr_wait,
    st_done,
    st_fault
  } state_t;

endpackage

// file: operand_address_generator.sv
/*
  Operand and branch-target address generator.
  Holds a small fetch sequencer for pointer-based modes.
  Assumes the decoder holds its inputs stable from start until done,
  and the memory side answers a pointer request with ptr_valid.
  Direct modes finish two edges after start; pointer modes finish
  two edges after the pointer answer is taken.
  Illegal class/mode pairs give a one-cycle fault and no result.
*/
module operand_address_generator (
  input  wire logic        clock,      // 10 MHz processor clock
  input  wire logic        rstn,       // Asynchronous reset, active low
  input  wire logic        start,      // One-cycle request from decoder
  input  wire logic [1:0]  addr_class, // Addressing class
  input  wire logic [2:0]  mode,       // Mode within class
  input  wire logic [7:0]  disp,       // Displacement field
  input  wire logic [15:0] local_base, // Local segment base
  input  wire logic [15:0] common_base,// Common segment base
  input  wire logic [15:0] ptr_base,   // Common pointer base
  input  wire logic [15:0] index_reg,  // Index register
  input  wire logic [15:0] prog_loc,   // Program location
  output logic             ptr_req,    // Pointer fetch request
  output logic [15:0]      ptr_addr,   // Pointer fetch address
  input  wire logic        ptr_valid,  // Pointer data valid
  input  wire logic [15:0] ptr_data,   // Fetched pointer
  output logic             done,       // Result valid pulse
  output logic             is_operand, // Result is an operand value
  output logic             fault,      // Illegal mode pulse
  output logic [15:0]      result      // Address or operand
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] zext(input logic [7:0] b);
    zext = {8'h00, b};
  endfunction

  function automatic logic [15:0] twice(input logic [7:0] b);
    twice = {7'h00, b, 1'b0};
  endfunction

  oag_mem_if am ();

  oag_adder u_add (
    .m (am)
  );

  oag_pkg::state_t state_ff;
  oag_pkg::state_t nxt_state;
  logic [15:0]     result_ff;
  logic [15:0]     nxt_result;
  logic            oper_ff;
  logic            nxt_oper;
  logic [15:0]     paddr_ff;
  logic [15:0]     nxt_paddr;
  logic [15:0]     pdata_ff;
  logic [15:0]     nxt_pdata;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire c0  = addr_class == 2'(oag_pkg::class_0);
  wire c0p = addr_class == 2'(oag_pkg::class_0p);
  wire c1  = addr_class == 2'(oag_pkg::class_1);
  wire c2  = addr_class == 2'(oag_pkg::class_2);
  wire c0a = c0 | c0p;

  wire m_dl  = mode == 3'(oag_pkg::direct_local);
  wire m_il  = mode == 3'(oag_pkg::indirect_local);
  wire m_ilx = mode == 3'(oag_pkg::indirect_local_indexed);
  wire m_dg  = mode == 3'(oag_pkg::direct_common);
  wire m_igx = mode == 3'(oag_pkg::indirect_common_indexed);
  wire m_imm = mode == 3'(oag_pkg::immediate);
  wire m_px  = mode == 3'(oag_pkg::immediate_indexed);
  wire m_rp  = mode == 3'(oag_pkg::relative_forward);
  wire m_rm  = mode == oag_pkg::MODE_RELATIVE_BACKWARD;
  wire m_ig  = mode == oag_pkg::MODE_INDIRECT_COMMON_BRANCH;

  // ****************************************************************
  // Legal mode table
  // ****************************************************************
  // Class 2 shares codes with class 0: code 1 is the local pointer
  // branch and code 4 the common pointer branch, so the class bits
  // must qualify every mode test below.

  // Class 0 six modes; 0' drops immediate
  wire ok_c0  = c0 & (m_dl | m_il | m_ilx | m_dg | m_igx | m_imm);
  wire ok_c0p = c0p & (m_dl | m_il | m_ilx | m_dg | m_igx);
  wire ok_c1  = c1 & (m_imm | m_px | m_dl);
  wire ok_c2  = c2 & (m_rp | m_rm | m_il | m_ig);
  wire legal  = ok_c0 | ok_c0p | ok_c1 | ok_c2;

  // Pointer fetch needed
  wire needs_ptr = (c0a & (m_il | m_ilx | m_igx)) | (c2 & (m_il | m_ig));
  // Pointer located via common segment
  wire via_common = (c0a & m_igx) | (c2 & m_ig);

  // ****************************************************************
  // Direct computation (no fetch)
  // ****************************************************************
  wire [15:0] dl_addr = local_base + zext(disp);
  wire [15:0] dg_addr = common_base + zext(disp);
  wire [15:0] fwd     = prog_loc + twice(disp);
  wire [15:0] bwd     = prog_loc - twice(disp);
  wire [15:0] px_val  = zext(disp) + index_reg;

  logic [15:0] direct_val;
  logic        direct_oper;
  always_comb begin
    direct_val  = dl_addr;
    direct_oper = 1'b0;
    if (c0a & m_dg) begin
      direct_val = dg_addr;
    end else if ((c0 | c1) & m_imm) begin
      direct_val  = zext(disp);
      direct_oper = 1'b1;
    end else if (c1 & m_px) begin
      direct_val  = px_val;
      direct_oper = 1'b1;
    end else if (c2 & m_rp) begin
      direct_val = fwd;
    end else if (c2 & m_rm) begin
      direct_val = bwd;
    end
  end

  // ****************************************************************
  // Pointer address select
  // ****************************************************************
  // Pointer lives in the common segment for the common-based modes
  wire [15:0] ptr_loc = via_common ? dg_addr : dl_addr;

  // ****************************************************************
  // Final sum after pointer fetch
  // ****************************************************************
  wire idx_mode = c0a & (m_ilx | m_igx);
  assign am.offs  = pdata_ff;
  assign am.base  = (c0a & m_igx) ? common_base : ptr_base;
  assign am.extra = idx_mode ? index_reg : oag_pkg::ZERO_EXT;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt_state  = state_ff;
    nxt_result = result_ff;
    nxt_oper   = oper_ff;
    nxt_paddr  = paddr_ff;
    nxt_pdata  = pdata_ff;
    case (state_ff)
      oag_pkg::st_idle: begin
        if (start) begin
          if (!legal) begin
            nxt_state = oag_pkg::st_fault;
          end else if (needs_ptr) begin
            nxt_paddr = ptr_loc;
            nxt_state = oag_pkg::st_ptr_req;
          end else begin
            nxt_result = direct_val;
            nxt_oper   = direct_oper;
            nxt_state  = oag_pkg::st_done;
          end
        end
      end
      // Request stands for exactly one cycle
      oag_pkg::st_ptr_req: begin
        nxt_state = oag_pkg::st_ptr_wait;
      end
      // Wait as long as the memory side needs
      oag_pkg::st_ptr_wait: begin
        if (ptr_valid) begin
          nxt_pdata = ptr_data;
          nxt_state = oag_pkg::st_done;
        end
      end
      oag_pkg::st_done: begin
        nxt_state = oag_pkg::st_idle;
      end
      oag_pkg::st_fault: begin
        nxt_state = oag_pkg::st_idle;
      end
      default: begin
        nxt_state = oag_pkg::st_idle;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Pointer sum is taken one edge after the pointer is captured
  wire  fetch_done = state_ff == oag_pkg::st_ptr_wait && ptr_valid;
  logic sum_pending_ff;

  // Indirect results take the adder output instead of the direct value
  wire [15:0] result_in = sum_pending_ff ? am.sum : nxt_result;
  wire        oper_in   = sum_pending_ff ? 1'b0 : nxt_oper;

  // Sequencer state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= oag_pkg::st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Result word, stands until the next result
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      result_ff <= oag_pkg::ADDR_RST;
    end else begin
      result_ff <= result_in;
    end
  end

  // Operand flag, follows the result word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      oper_ff <= 1'b0;
    end else begin
      oper_ff <= oper_in;
    end
  end

  // Pointer fetch address
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      paddr_ff <= oag_pkg::ADDR_RST;
    end else begin
      paddr_ff <= nxt_paddr;
    end
  end

  // Captured pointer word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pdata_ff <= oag_pkg::ADDR_RST;
    end else begin
      pdata_ff <= nxt_pdata;
    end
  end

  // Marks the cycle in which the pointer sum is loaded
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sum_pending_ff <= 1'b0;
    end else begin
      sum_pending_ff <= fetch_done;
    end
  end

  // ****************************************************************
  // Result strobe
  // ****************************************************************
  // Indirect results: done rises on the same edge that loads the sum
  wire  done_in = (state_ff == oag_pkg::st_done) || sum_pending_ff;
  logic done_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= done_in;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ptr_req    = state_ff == oag_pkg::st_ptr_req;
  assign ptr_addr   = paddr_ff;
  assign done       = done_ff;
  assign is_operand = oper_ff;
  assign fault      = state_ff == oag_pkg::st_fault;
  assign result     = result_ff;

endmodule

// file: operand_address_generator_tb_top.sv
/* Self-checking bench for operand_address_generator.
   Assumes the pointer store model and the bound monitor. */
module operand_address_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rstn = 0, start = 0, ptr_valid, ptr_req, done, is_operand, fault;
  logic [1:0] addr_class = 0, pdelay = 0;
  logic [2:0] mode = 0;
  logic [7:0] disp = 0;
  logic [15:0] local_base = 0, common_base = 0, ptr_base = 0, index_reg = 0, prog_loc = 0;
  logic [15:0] pdata = 0, ptr_data, ptr_addr, result;
  int num_errors = 0, n_compared = 0;
  logic [4:0] tbl [19] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h15, 5'h16, 5'h10,
    5'h1f, 5'h1e, 5'h19, 5'h1c};
  operand_address_generator uut (.clock, .rstn, .start, .addr_class, .mode, .disp, .local_base,
    .common_base, .ptr_base, .index_reg, .prog_loc, .ptr_req, .ptr_addr, .ptr_valid, .ptr_data,
    .done, .is_operand, .fault, .result);
  oag_memory_model mem (.clock, .ptr_req, .pdata, .pdelay, .ptr_valid, .ptr_data);
  initial forever #50 clock = ~clock;
  function automatic logic [16:0] expect_of(logic [4:0] k);
    logic [15:0] d;
    d = {8'h00, disp};
    case (k)
      5'h00, 5'h08, 5'h10: return {1'b0, local_base + d};
      5'h03, 5'h0b: return {1'b0, common_base + d};
      5'h01, 5'h09, 5'h19, 5'h1c: return {1'b0, ptr_base + pdata};
      5'h02, 5'h0a: return {1'b0, ptr_base + pdata + index_reg};
      5'h04, 5'h0c: return {1'b0, common_base + pdata + index_reg};
      5'h05, 5'h15: return {1'b1, d};
      5'h16: return {1'b1, d + index_reg};
      5'h1f: return {1'b0, prog_loc + (d << 1)};
      default: return {1'b0, prog_loc - (d << 1)};
    endcase
  endfunction
  function automatic logic [15:0] paddr_of(logic [4:0] k);
    return (k == 5'h04 || k == 5'h0c || k == 5'h1c) ? common_base + disp : local_base + disp;
  endfunction
  task chk(logic [17:0] got, logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task run(logic [4:0] k, logic r);
    @(posedge clock);
    #1;
    if (r) begin
      {disp, local_base, common_base} = {$urandom, $urandom};
      {ptr_base, index_reg, prog_loc, pdata} = {$urandom, $urandom};
      pdelay = 2'($urandom_range(3, 0));
    end
    {addr_class, mode} = k;
    start = 1;
    @(posedge clock);
    #1 start = 0;
    repeat (12) begin
      if (ptr_req === 1'b1) chk({2'h0, ptr_addr}, {2'h0, paddr_of(k)});
      if (done === 1'b1 || fault === 1'b1) break;
      @(posedge clock);
      #1;
    end
    if (k == 5'h0d) chk({16'h0, done, fault}, 18'h1);
    else chk({done, is_operand, result}, {1'b1, expect_of(k)});
  endtask
  task stop_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h6c94));
    repeat (16) @(posedge clock);
    #1 rstn = 1;
    // Wrap of every sum except the forward target, slow pointer answer
    {disp, local_base, common_base, ptr_base} = {8'hff, 16'hffff, 16'hff80, 16'hfff0};
    {index_reg, prog_loc, pdata, pdelay} = {16'hffff, 16'h0010, 16'hffff, 2'h3};
    foreach (tbl[i]) run(tbl[i], 1'b0);
    repeat (20) foreach (tbl[i]) run(tbl[i], 1'b1);
    stop_test();
  end
  initial begin
    #600000;
    num_errors++;
    stop_test();
  end
endmodule
